//--- pad_mux_pkg.sv
// Purpose: Shared constants and types for the bank-15 pad function selector.
// Assumes: One 32-bit register, eight 4-bit fields, one field per pad.
// Notes:   Pad p is steered by register bits 4p+3 down to 4p.
package pad_mux_pkg;

    // Byte offset of the select register inside the slave window.
    localparam logic [11:0] SEL_REG_OFFSET = 12'h000;
    // Value of the select register after reset.
    localparam logic [31:0] SEL_REG_RESET  = 32'h0000_0000;
    // Width of one select field and number of pads served.
    localparam int          FIELD_W        = 4;
    localparam int          NUM_PADS       = 8;
    // Pads whose fifth function is a core output rather than a pad input.
    localparam logic [7:0]  ALT_IS_OUTPUT  = 8'hfc;

    // AHB-Lite encodings used by the slave.
    localparam logic [2:0]  HSIZE_WORD     = 3'h2;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

    // Function codes held in each field; every other code is reserved.
    typedef enum logic [3:0] {
        FUNC_RT_IN  = 4'h0,
        FUNC_VIDEO  = 4'h1,
        FUNC_HOST   = 4'h2,
        FUNC_PAR    = 4'h4,
        FUNC_ALT    = 4'h8
    } pad_func_t;

    // Whole state of the top module.
    typedef struct packed {
        logic [31:0] pad_function_select_15;
    } sel_state_t;

    // Extracts the select field of one pad.
    function automatic logic [3:0] field_of(input logic [31:0] r, input int pad);
        field_of = r[pad*FIELD_W +: FIELD_W];
    endfunction : field_of

endpackage : pad_mux_pkg

//--- reg_access_if.sv
// Purpose: Carries register writes and read data from the bus slave to the register.
// Assumes: Single register, whole-word writes only.
// Notes:   wr_en is a one-cycle pulse in the write data phase.
`timescale 1ns/1ns
interface reg_access_if;
    logic        wr_en;    // Commit wr_data at the coming edge.
    logic [31:0] wr_data;  // Word to store.
    logic [31:0] rd_data;  // Current register contents.
    modport bus  (output wr_en, output wr_data, input rd_data);
    modport regs (input wr_en, input wr_data, output rd_data);
endinterface : reg_access_if

//--- ahb_reg_port.sv
// Purpose: AHB-Lite slave in front of the single select register.
// Assumes: Zero wait states; response always OKAY.
// Notes:   Unmapped or sub-word accesses read zero and write nothing.
`timescale 1ns/1ns
module ahb_reg_port
    import pad_mux_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rstn,
    // AHB-Lite slave side.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Register side.
    reg_access_if.bus        rbus
);
    import pad_mux_pkg::*;

    // Data phase bookkeeping captured from the address phase.
    typedef struct packed {
        logic wr_pend;
        logic rd_pend;
    } phase_t;

    phase_t state;       // Registered phase flags.
    phase_t next_state;  // Next value of the phase flags.
    logic   take;        // A valid address phase is accepted this cycle.
    logic   hit;         // Address phase targets the register as a whole word.

    // Decodes the address phase; only NONSEQ word accesses to the register count.
    always_comb begin
        take = hsel && hready && (htrans == HTRANS_NONSEQ);
        hit  = (haddr[11:0] == SEL_REG_OFFSET) && (hsize == HSIZE_WORD);
        next_state.wr_pend = take && hit && hwrite;
        next_state.rd_pend = take && hit && !hwrite;
    end

    // Registers the phase flags.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // The slave never stalls, so a write lands at the end of its data phase.
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign rbus.wr_en   = state.wr_pend;
    assign rbus.wr_data = hwdata;
    // Read data comes straight from the register flops.
    assign hrdata       = state.rd_pend ? rbus.rd_data : 32'h0000_0000;

endmodule : ahb_reg_port

//--- pad_route.sv
// Purpose: Steers one pad to one of five functions.
// Assumes: Function codes from pad_mux_pkg; reserved codes leave the pad idle.
// Notes:   Purely combinational so a pad clock is never delayed.
`timescale 1ns/1ns
module pad_route
    import pad_mux_pkg::*;
(
    // Field code for this pad.
    input  wire logic [3:0] sel,
    // Pad side; output enable is active low.
    input  wire logic       pad_in,
    output logic            pad_out,
    output logic            pad_oe_n,
    // Functions that receive the pad level.
    output logic            rt_in,
    output logic            video_in,
    output logic            host_in,
    output logic            par_in,
    output logic            alt_in,
    // Functions that may drive the pad.
    input  wire logic       host_out,
    input  wire logic       host_oe_n,
    input  wire logic       par_out,
    input  wire logic       par_oe_n,
    input  wire logic       alt_out,
    input  wire logic       alt_oe_n
);
    import pad_mux_pkg::*;

    // Unselected functions see zero; reserved codes release the pad.
    always_comb begin
        pad_out  = 1'b0;
        pad_oe_n = 1'b1;
        rt_in    = 1'b0;
        video_in = 1'b0;
        host_in  = 1'b0;
        par_in   = 1'b0;
        alt_in   = 1'b0;
        unique case (sel)
            FUNC_RT_IN: begin
                rt_in = pad_in;
            end
            FUNC_VIDEO: begin
                video_in = pad_in;
            end
            FUNC_HOST: begin
                host_in  = pad_in;
                pad_out  = host_out;
                pad_oe_n = host_oe_n;
            end
            FUNC_PAR: begin
                par_in   = pad_in;
                pad_out  = par_out;
                pad_oe_n = par_oe_n;
            end
            FUNC_ALT: begin
                alt_in   = pad_in;
                pad_out  = alt_out;
                pad_oe_n = alt_oe_n;
            end
            default: begin
                // Reserved code: nothing is routed.
                pad_out  = 1'b0;
            end
        endcase
    end

endmodule : pad_route

//--- pad_function_select_bank15.sv
// Purpose: Select register and pad routing for eight multiplexed pads.
// Assumes: AHB-Lite access, one clock, synchronous active-low reset.
// Notes:   Pad p uses field bits 4p+3..4p; pad 7 is the top field.
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
module pad_function_select_bank15
    import pad_mux_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rstn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Pads, indexed by pad number.
    input  wire logic [7:0]  pad_in,
    output logic [7:0]       pad_out,
    output logic [7:0]       pad_oe_n,
    // Real-time core inputs fed from the pads.
    output logic [7:0]       rt_core_input_bits,
    // Video port inputs fed from the pads.
    output logic [7:0]       video_in_data_bits,
    // Host port data, two-way.
    output logic [7:0]       host_port_data_bits_in,
    input  wire logic [7:0]  host_port_data_bits_out,
    input  wire logic [7:0]  host_port_data_bits_oe_n,
    // Parallel port data, two-way.
    output logic [7:0]       parallel_port_data_bits_in,
    input  wire logic [7:0]  parallel_port_data_bits_out,
    input  wire logic [7:0]  parallel_port_data_bits_oe_n,
    // Core 0 outputs on pads 7 to 2.
    input  wire logic [7:2]  rt_core0_output_bits,
    // Reduced media interface inputs on pads 1 and 0.
    output logic             reduced_if_carrier_valid,
    output logic             reduced_if_ref_clock_50mhz
);
    import pad_mux_pkg::*;

    sel_state_t   state;       // Registered block state.
    sel_state_t   next_state;  // Next value of the block state.
    reg_access_if rif ();      // Link to the bus slave.

    logic [7:0] alt_out;   // Alternate function drive level per pad.
    logic [7:0] alt_oe_n;  // Alternate function drive enable per pad.
    logic [7:0] alt_in;    // Alternate function input per pad.

    // Names for the outermost fields, handy in waveforms.
    logic [3:0] pad_select_field_top;
    logic [3:0] pad_select_field_bottom;
    assign pad_select_field_top    = state.pad_function_select_15[31:28];
    assign pad_select_field_bottom = state.pad_function_select_15[3:0];

    // Bus slave; it never inserts wait states.
    ahb_reg_port u_bus (
        .mclk      (mclk),
        .rstn      (rstn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .rbus      (rif)
    );

    // A write replaces the whole word; all fields are stored as written.
    // Reserved codes are kept too, so software reads back what it wrote.
    always_comb begin
        next_state = state;
        if (rif.wr_en) begin
            next_state.pad_function_select_15 = rif.wr_data;
        end
    end

    // Reset puts every pad on its real-time core input.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state.pad_function_select_15 <= SEL_REG_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Read path shows the stored codes.
    assign rif.rd_data = state.pad_function_select_15;

    // Alternate functions: core outputs on pads 7 to 2 always want to drive.
    // Pads 1 and 0 carry inputs to the media interface, so they never drive.
    genvar p;
    generate
        for (p = 0; p < NUM_PADS; p++) begin : g_alt
            if (ALT_IS_OUTPUT[p]) begin : g_drv
                assign alt_out[p]  = rt_core0_output_bits[p];
                assign alt_oe_n[p] = 1'b0;
            end else begin : g_rcv
                assign alt_out[p]  = 1'b0;
                assign alt_oe_n[p] = 1'b1;
            end
        end
    endgenerate

    assign reduced_if_carrier_valid   = alt_in[1];
    assign reduced_if_ref_clock_50mhz = alt_in[0];

    // One router per pad; the route follows the register with no delay.
    generate
        for (p = 0; p < NUM_PADS; p++) begin : g_pad
            pad_route u_route (
                .sel       (field_of(state.pad_function_select_15, p)),
                .pad_in    (pad_in[p]),
                .pad_out   (pad_out[p]),
                .pad_oe_n  (pad_oe_n[p]),
                .rt_in     (rt_core_input_bits[p]),
                .video_in  (video_in_data_bits[p]),
                .host_in   (host_port_data_bits_in[p]),
                .par_in    (parallel_port_data_bits_in[p]),
                .alt_in    (alt_in[p]),
                .host_out  (host_port_data_bits_out[p]),
                .host_oe_n (host_port_data_bits_oe_n[p]),
                .par_out   (parallel_port_data_bits_out[p]),
                .par_oe_n  (parallel_port_data_bits_oe_n[p]),
                .alt_out   (alt_out[p]),
                .alt_oe_n  (alt_oe_n[p])
            );
        end
    endgenerate

    // Checks below run on the single clock and pause in reset.
    // Reserved codes are never written by software, so no check here covers them.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // Pad 7 on core output drives the pad from that output.
    property p_top_alt;
        (pad_select_field_top == FUNC_ALT)
            |-> (pad_out[7] == rt_core0_output_bits[7]) && !pad_oe_n[7];
    endproperty
    a_top_alt: assert property (p_top_alt)
        else $error("pad 7 alternate drive wrong");

    // Pad 6 on host data follows the host drive and reports the pad.
    property p_pad6_host;
        (state.pad_function_select_15[27:24] == FUNC_HOST)
            |-> (pad_out[6] == host_port_data_bits_out[6])
             && (pad_oe_n[6] == host_port_data_bits_oe_n[6])
             && (host_port_data_bits_in[6] == pad_in[6]);
    endproperty
    a_pad6_host: assert property (p_pad6_host)
        else $error("pad 6 host route wrong");

    // Pad 5 on parallel data follows the parallel port.
    property p_pad5_par;
        (state.pad_function_select_15[23:20] == FUNC_PAR)
            |-> (pad_out[5] == parallel_port_data_bits_out[5])
             && (pad_oe_n[5] == parallel_port_data_bits_oe_n[5])
             && (parallel_port_data_bits_in[5] == pad_in[5]);
    endproperty
    a_pad5_par: assert property (p_pad5_par)
        else $error("pad 5 parallel route wrong");

    // Pad 4 on video is an input only; the pad must stay released.
    property p_pad4_video;
        (state.pad_function_select_15[19:16] == FUNC_VIDEO)
            |-> pad_oe_n[4] && (video_in_data_bits[4] == pad_in[4])
             && !rt_core_input_bits[4];
    endproperty
    a_pad4_video: assert property (p_pad4_video)
        else $error("pad 4 video route wrong");

    // Pad 3 on core input leaves the video and host inputs at zero.
    property p_pad3_rt;
        (state.pad_function_select_15[15:12] == FUNC_RT_IN)
            |-> (rt_core_input_bits[3] == pad_in[3]) && pad_oe_n[3]
             && !video_in_data_bits[3] && !host_port_data_bits_in[3];
    endproperty
    a_pad3_rt: assert property (p_pad3_rt)
        else $error("pad 3 core input route wrong");

    // Pad 2 switched to core output by a write drives on the next cycle.
    property p_pad2_switch;
        (rif.wr_en && (rif.wr_data[11:8] == FUNC_ALT))
            |=> (pad_out[2] == rt_core0_output_bits[2]) && !pad_oe_n[2];
    endproperty
    a_pad2_switch: assert property (p_pad2_switch)
        else $error("pad 2 did not switch to core output");

    // Pad 1 alternate is the carrier valid input and never drives.
    property p_pad1_crs;
        (state.pad_function_select_15[7:4] == FUNC_ALT)
            |-> pad_oe_n[1] && (reduced_if_carrier_valid == pad_in[1]);
    endproperty
    a_pad1_crs: assert property (p_pad1_crs)
        else $error("pad 1 carrier valid route wrong");

    // Pad 0 alternate is the reference clock input and never drives.
    property p_pad0_clk;
        (pad_select_field_bottom == FUNC_ALT)
            |-> pad_oe_n[0] && (reduced_if_ref_clock_50mhz == pad_in[0])
             && !rt_core_input_bits[0];
    endproperty
    a_pad0_clk: assert property (p_pad0_clk)
        else $error("pad 0 reference clock route wrong");

    // First cycle after reset: cleared register and every pad on core input.
    property p_reset_clear;
        $past(!rstn)
            |-> (state.pad_function_select_15 == SEL_REG_RESET)
             && (pad_oe_n == 8'hff) && (rt_core_input_bits == pad_in);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("register not cleared after reset");

    // A write is stored at the next edge and then held until the next write.
    property p_write_lands;
        rif.wr_en ##1 !rif.wr_en
            |-> (state.pad_function_select_15 == $past(rif.wr_data, 1))
             && (rif.rd_data == state.pad_function_select_15);
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("written word not stored");

    // Without a write the register does not move.
    property p_hold;
        !rif.wr_en |=> $stable(state.pad_function_select_15);
    endproperty
    a_hold: assert property (p_hold)
        else $error("register changed without a write");

    // A read straight after a write's data phase returns the written word.
    // The middle cycle must be idle, or a pipelined second write would land first.
    property p_readback;
        (hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite
            && (hsize == HSIZE_WORD) && (haddr[11:0] == SEL_REG_OFFSET))
            ##1 !(hsel && (htrans == HTRANS_NONSEQ))
            ##1 (hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite
            && (hsize == HSIZE_WORD) && (haddr[11:0] == SEL_REG_OFFSET))
            |=> (hrdata == $past(hwdata, 2));
    endproperty
    a_readback: assert property (p_readback)
        else $error("read back differs from written word");

    // Pad 7 on video only listens.
    // Video inputs never drive, so the pad must stay released.
    property p_pad7_video;
        (pad_select_field_top == FUNC_VIDEO)
            |-> pad_oe_n[7] && !rt_core_input_bits[7]
             && (video_in_data_bits[7] == pad_in[7]);
    endproperty
    a_pad7_video: assert property (p_pad7_video)
        else $error("pad 7 video route wrong");

    // Pad 6 on core output drives it.
    property p_pad6_alt;
        (state.pad_function_select_15[27:24] == FUNC_ALT)
            |-> !pad_oe_n[6] && !rt_core_input_bits[6]
             && (pad_out[6] == rt_core0_output_bits[6]);
    endproperty
    a_pad6_alt: assert property (p_pad6_alt)
        else $error("pad 6 core output route wrong");

    // Pad 5 on core input stays released.
    property p_pad5_rt;
        (state.pad_function_select_15[23:20] == FUNC_RT_IN)
            |-> pad_oe_n[5] && !parallel_port_data_bits_in[5]
             && (rt_core_input_bits[5] == pad_in[5]);
    endproperty
    a_pad5_rt: assert property (p_pad5_rt)
        else $error("pad 5 core input route wrong");

    // Pad 4 on host data follows the host port.
    property p_pad4_host;
        (state.pad_function_select_15[19:16] == FUNC_HOST)
            |-> (pad_oe_n[4] == host_port_data_bits_oe_n[4])
             && (pad_out[4] == host_port_data_bits_out[4]);
    endproperty
    a_pad4_host: assert property (p_pad4_host)
        else $error("pad 4 host route wrong");

    // Pad 1 on video feeds video bit 1 only.
    property p_pad1_video;
        (state.pad_function_select_15[7:4] == FUNC_VIDEO)
            |-> pad_oe_n[1] && !reduced_if_carrier_valid
             && (video_in_data_bits[1] == pad_in[1]);
    endproperty
    a_pad1_video: assert property (p_pad1_video)
        else $error("pad 1 video route wrong");

endmodule : pad_function_select_bank15

//--- pad_partner_model.sv
// Purpose: Far-side model of the pads and of the peripherals that sit behind the pad selector.
// Assumes: One clock; every level changes just after a rising edge and is steady by the falling edge.
// Notes:   Levels follow a free-running count, so each pad and each host and parallel port output keeps changing; core0_out stays zero for the first 256 cycles.
`timescale 1ns/1ns
module pad_partner_model (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       rstn,
    // Pad side of the selector.
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe_n,
    output logic      [7:0] pad_in,
    // Peripheral outputs that may drive the pads.
    output logic      [7:0] host_out,
    output logic      [7:0] host_oe_n,
    output logic      [7:0] par_out,
    output logic      [7:0] par_oe_n,
    output logic      [7:2] core0_out
);
    logic [15:0] tick;      // Free-running count behind every level.
    logic [7:0]  ext_level; // Level the board puts on a pad that nobody on chip drives.

    // The count runs through reset too, so no level ever freezes at a value the simulator chose.
    initial tick = 16'h0000;
    always @(posedge mclk) begin
        tick <= tick + 16'h0001;
    end

    // The peripherals drive and release the pads in changing patterns, so both directions are seen.
    always_comb begin
        ext_level = tick[7:0] ^ 8'h5a;
        host_out  = tick[8:1];
        host_oe_n = tick[9:2] ^ 8'h33;
        par_out   = ~tick[7:0];
        par_oe_n  = tick[10:3] ^ 8'hc5;
        core0_out = tick[13:8];
    end

    // The wire carries the chip's level wherever the chip drives it, the board's level elsewhere.
    always_comb begin
        for (int p = 0; p < 8; p++) begin
            pad_in[p] = pad_oe_n[p] ? ext_level[p] : pad_out[p];
        end
    end
endmodule : pad_partner_model

//--- pad_function_select_bank15_tb.sv
// Purpose: Self-checking bench for the bank-15 pad selector: register access and pad routing.
// Assumes: Zero-wait AHB-Lite slave at offset 0; pads follow the register one cycle after a write.
// Notes:   Expected routing is rebuilt here from the field codes, never taken from the design.
`timescale 1ns/1ns
module pad_function_select_bank15_tb;
    import pad_mux_pkg::*;

    logic        mclk, rstn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  pad_in, pad_out, pad_oe_n, rt_bits, video_bits, host_in, host_out, host_oe_n;
    logic [7:0]  par_in, par_out, par_oe_n;
    logic [7:2]  core0_out;
    logic        carrier_valid, ref_clock;
    logic [31:0] regv;      // Register contents that the bench expects.
    int          fails;     // Mismatches seen.
    int          cmp_count; // Comparisons made.

    // The single slave's ready is the bus ready.
    assign hready = hreadyout;

    pad_function_select_bank15 i_pad_function_select_bank15 (
        .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .rt_core_input_bits(rt_bits), .video_in_data_bits(video_bits),
        .host_port_data_bits_in(host_in), .host_port_data_bits_out(host_out),
        .host_port_data_bits_oe_n(host_oe_n), .parallel_port_data_bits_in(par_in),
        .parallel_port_data_bits_out(par_out), .parallel_port_data_bits_oe_n(par_oe_n),
        .rt_core0_output_bits(core0_out), .reduced_if_carrier_valid(carrier_valid),
        .reduced_if_ref_clock_50mhz(ref_clock));

    pad_partner_model i_pad_partner_model (
        .mclk(mclk), .rstn(rstn), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_in(pad_in),
        .host_out(host_out), .host_oe_n(host_oe_n), .par_out(par_out), .par_oe_n(par_oe_n),
        .core0_out(core0_out));

    // Clock at 100 MHz.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // Compares one result word and counts it.
    task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    // One single AHB transfer; the wait for ready is bounded so a dead slave cannot hang the bench.
    task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                            input logic [2:0] sz, output logic [31:0] rd);
        int n;
        @(posedge mclk);
        hsel <= 1'b1; htrans <= HTRANS_NONSEQ; haddr <= a; hwrite <= wr; hsize <= sz;
        n = 0;
        do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 50);
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= wd;
        do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 50);
        rd = hrdata;
        if (n >= 50) begin
            fails++;
        end
    endtask : ahb_xfer

    // Reads the register and compares it with the bench's copy.
    task automatic read_check(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        ahb_xfer(1'b0, a, 32'h0000_0000, HSIZE_WORD, rd);
        check_val({32'h0, rd}, {32'h0, exp});
    endtask : read_check

    // Rebuilds every routed output from the field codes and compares, over several pad patterns.
    task automatic check_pads(input int cycles);
        logic [7:0] e_rt, e_vid, e_host, e_par, e_oe, e_out;
        logic [3:0] c;
        for (int k = 0; k < cycles; k++) begin
            @(negedge mclk);
            for (int p = 0; p < 8; p++) begin
                c = regv[p*4 +: 4];
                e_rt[p] = (c == 4'h0) & pad_in[p];
                e_vid[p] = (c == 4'h1) & pad_in[p];
                e_host[p] = (c == 4'h2) & pad_in[p];
                e_par[p] = (c == 4'h4) & pad_in[p];
                e_oe[p] = (c == 4'h2) ? host_oe_n[p] : (c == 4'h4) ? par_oe_n[p] : ~(c == 4'h8 && p >= 2);
                e_out[p] = (c == 4'h2) ? host_out[p] : (c == 4'h4) ? par_out[p] : (p >= 2 && core0_out[p]);
            end
            check_val({12'h0, hreadyout, hresp, rt_bits, video_bits, host_in, par_in, carrier_valid,
                       ref_clock, pad_oe_n, pad_out & ~pad_oe_n},
                      {12'h0, 1'b1, 1'b0, e_rt, e_vid, e_host, e_par, regv[7:4] == 4'h8 && pad_in[1],
                       regv[3:0] == 4'h8 && pad_in[0], e_oe, e_out & ~e_oe});
        end
    endtask : check_pads

    // Writes a word at offset zero, then checks routing from the very next cycle and the read-back.
    task automatic write_and_check(input logic [31:0] v);
        logic [31:0] rd;
        ahb_xfer(1'b1, 32'h0000_0000, v, HSIZE_WORD, rd);
        regv = v;
        check_pads(4);
        read_check(32'h0000_0000, v);
    endtask : write_and_check

    // After reset every field is zero and every pad feeds its core input.
    task automatic sc_reset_state();
        read_check(32'h0000_0000, 32'h0000_0000);
        check_pads(3);
    endtask : sc_reset_state

    // Every legal code in every field, then two mixed words that each use all five codes across the pads.
    task automatic sc_all_codes();
        logic [3:0] legal [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
        for (int i = 0; i < 5; i++) begin
            write_and_check({8{legal[i]}});
        end
        write_and_check(32'h1248_0124);
        write_and_check(32'h8421_0888);
    endtask : sc_all_codes

    // Off-offset and sub-word writes must leave the register alone; the empty offset reads zero.
    task automatic sc_refused();
        logic [31:0] rd;
        ahb_xfer(1'b1, 32'h0000_0004, 32'h4444_4444, HSIZE_WORD, rd);
        ahb_xfer(1'b1, 32'h0000_0000, 32'h2222_2222, 3'h0, rd);
        read_check(32'h0000_0004, 32'h0000_0000);
        read_check(32'h0000_0000, regv);
        check_pads(2);
    endtask : sc_refused

    // A read issued right after a write's data phase sees the new word.
    task automatic sc_write_then_read();
        logic [31:0] rd;
        ahb_xfer(1'b1, 32'h0000_0000, 32'h4821_0084, HSIZE_WORD, rd);
        regv = 32'h4821_0084;
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= 1'b0;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        do @(posedge mclk); while (hready !== 1'b1);
        check_val({32'h0, hrdata}, {32'h0, regv});
        check_pads(2);
    endtask : sc_write_then_read

    // A reset in mid-run brings every field back to zero.
    task automatic sc_mid_reset();
        write_and_check(32'h8888_8888);
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        regv = 32'h0000_0000;
        read_check(32'h0000_0000, 32'h0000_0000);
        check_pads(2);
    endtask : sc_mid_reset

    // Main sequence.
    initial begin
        fails = 0; cmp_count = 0; regv = 32'h0000_0000;
        rstn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = HSIZE_WORD; hwdata = 32'h0;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        sc_reset_state();
        sc_all_codes();
        sc_refused();
        sc_write_then_read();
        sc_mid_reset();
        complete_run();
    end

    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        #20000;
        fails++;
        complete_run();
    end
endmodule : pad_function_select_bank15_tb
